// file: verilog/temp_comp_pkg.sv
// Purpose: Constants for the temperature readout and compensation block
// Assumes: Byte-wide register port of the serial slave, 40 MHz ref_clk
// Notes: Notes on behaviour follow
// Notes on behaviour
// - Temperature is a 10-bit code; high byte holds bits 9..8, rest zero.
// - Published code is the average of two successive conversions.
// - Code is in half-kelvin steps; code/2 - 273 gives Celsius.
// - Net correction is twice ppm correction: initial term minus curvature term.
// - Initial term comes from initial trim and fine trim registers.
// - Curvature is coefficient times (T - turnover) squared, divided by 4096.
// - Coefficient is cold-side or hot-side, chosen by current temperature.
// - T is raw half-kelvin reading; turnover reference is 596 plus field.
// - Turnover field is sign-magnitude, half-degree steps around 25.0.
// - Turnover field recalled at power-up, read-only, host writes ignored.
// - Hot coefficient is 7-bit magnitude of crystal coefficient times 2048.
// - Hot coefficient recalled at power-up, read-only to the host.
// - Correction initial term is initialTrim + fineTrim, unscaled, with no digital offset.
package temp_comp_pkg;
	localparam logic [7:0]  ADDR_TURNOVER   = 8'h2c;
	localparam logic [7:0]  ADDR_HOT_COEFF  = 8'h2d;
	localparam logic [7:0]  ADDR_TEMP_LOW   = 8'h28;
	localparam logic [7:0]  ADDR_TEMP_HIGH  = 8'h29;
	localparam logic [7:0]  ADDR_CORR_LOW   = 8'h2a;
	localparam logic [7:0]  ADDR_CORR_HIGH  = 8'h2b;
	localparam logic [7:0]  TURNOVER_RESET  = 8'h00;
	localparam logic [7:0]  HOT_COEFF_RESET = 8'h00;
	localparam logic [11:0] TURNOVER_BASE   = 12'h254; // 596
	localparam int          CURV_SHIFT      = 12;      // Divide by 4096
	localparam logic [7:0]  DIGITAL_OFFSET  = 8'h10;   // 16
	localparam int          TEMP_BITS       = 10;
	localparam int          CORR_BITS       = 16;
	localparam int          CLK_HZ          = 40000000;
	localparam int          CONV_US         = 1000;
	localparam int          CONV_CYCLES     = CLK_HZ / 1000000 * CONV_US;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_FIRST  = 2'b01,
		ST_SECOND = 2'b11,
		ST_CALC   = 2'b10
	} conv_state_t;
endpackage

// file: verilog/corr_calc.sv
// Purpose: Compute net frequency correction from trim and curvature terms
// Assumes: Inputs steady while start pulse issued; one-cycle result latency
// Notes: Result registered; negative curvature magnitude is subtracted
`timescale 1ns/10ps
module corr_calc
	import temp_comp_pkg::*;
(
	input  wire logic                   ref_clk,     // System clock
	input  wire logic                   reset,       // Async reset
	input  wire logic                   start,       // Compute strobe
	input  wire logic [TEMP_BITS-1:0]   tempCode,    // Half-kelvin reading
	input  wire logic [11:0]            turnRef,     // Turnover reference
	input  wire logic [7:0]             coeff,       // Selected coefficient
	input  wire logic [7:0]             initialTrim, // Initial offset trim
	input  wire logic [7:0]             fineTrim,    // Fine trim
	output logic      [CORR_BITS-1:0]   netCorr      // Twice ppm correction
);
	logic signed [12:0] diff;
	logic        [25:0] square;
	logic        [33:0] prod;
	logic        [15:0] curvTerm;
	logic signed [15:0] initTerm;

	// Curvature: coefficient times squared distance, scaled down
	assign diff     = $signed({1'b0, 2'b00, tempCode}) - $signed({1'b0, turnRef});
	assign square   = 26'(diff * diff);
	assign prod     = 34'(square * coeff);
	assign curvTerm = 16'(prod >> CURV_SHIFT);
	// Initial offset built from both trims; scaling of fine trim kept simple
	assign initTerm = 16'($signed({8'h00, initialTrim}) + $signed({8'h00, fineTrim}));
	// Crystal coefficients are negative, so the curvature pulls down
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			netCorr <= '0;
		end else if (start) begin
			netCorr <= 16'(initTerm - $signed(curvTerm));
		end
	end
endmodule

// file: verilog/temp_comp.sv
// Purpose: Temperature readout registers and crystal compensation core
// Assumes: Byte register port from the serial slave, same clock domain
// Notes: Reset stands for the power-up recall of production values
`timescale 1ns/10ps
module temp_comp
	import temp_comp_pkg::*;
(
	input  wire logic       ref_clk,        // 40 MHz clock
	input  wire logic       reset,          // Async reset, power-up recall
	input  wire logic [7:0] recallTurnover, // Production turnover value
	input  wire logic [7:0] recallHotCoeff, // Production hot coefficient
	input  wire logic [7:0] coldCoeff,      // Cold-side coefficient
	input  wire logic [7:0] initialTrim,    // Initial trim register
	input  wire logic [7:0] fineTrim,       // Fine trim register
	input  wire logic       tempSenseEnable,// Host sense enable bit
	input  wire logic       adcValid,       // Converter sample strobe
	input  wire logic [9:0] adcCode,        // Converter reading
	input  wire logic       regWrite,       // Register write strobe
	input  wire logic       regRead,        // Register read strobe
	input  wire logic [7:0] regAddr,        // Register address
	input  wire logic [7:0] regWdata,       // Write data (ignored here)
	output logic      [7:0] regRdata,       // Read data
	output logic            convStart,      // Converter start request
	output logic     [15:0] netCorrection   // Twice ppm correction
);
	conv_state_t      state;
	conv_state_t      next_state;
	logic [7:0]       turnover;
	logic [7:0]       hotCoeff;
	logic [9:0]       firstSample;
	logic [9:0]       tempCode;
	logic             recallDone;
	logic [15:0]      corrValue;
	logic             calcStrobe;
	logic [31:0]      waitCount;
	logic [11:0]      turnRef;
	logic [11:0]      turnStep;
	logic [7:0]       selCoeff;
	logic [10:0]      sampleSum;
	logic [7:0]       next_rdata;
	logic             waitDone;

	// Sign-magnitude field: bit 4 set steps downward from 25.0
	function automatic logic [11:0] turn_ref(input logic [4:0] field);
		logic [11:0] mag;
		mag = {8'h00, field[3:0]};
		turn_ref = field[4] ? TURNOVER_BASE - mag : TURNOVER_BASE + mag;
	endfunction

	assign turnRef  = turn_ref(turnover[4:0]);
	assign turnStep = turnRef;
	assign selCoeff = ({2'b00, tempCode} > turnStep) ?
		{1'b0, hotCoeff[6:0]} : coldCoeff;
	assign sampleSum = {1'b0, firstSample} + {1'b0, adcCode};
	assign waitDone  = (waitCount == 32'(CONV_CYCLES - 1));

	// Recall production values once after reset; writes never reach them
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			turnover   <= TURNOVER_RESET;
			hotCoeff   <= HOT_COEFF_RESET;
			recallDone <= 1'b0;
		end else if (!recallDone) begin
			turnover   <= {3'b000, recallTurnover[4:0]};
			hotCoeff   <= {1'b0, recallHotCoeff[6:0]};
			recallDone <= 1'b1;
		end
	end

	// Conversion sequencer: two samples, then average and compute
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (tempSenseEnable && recallDone && waitDone)
					next_state = ST_FIRST;
			end
			ST_FIRST: begin
				if (!tempSenseEnable)
					next_state = ST_IDLE;
				else if (adcValid)
					next_state = ST_SECOND;
			end
			ST_SECOND: begin
				if (!tempSenseEnable)
					next_state = ST_IDLE;
				else if (adcValid)
					next_state = ST_CALC;
			end
			ST_CALC:   next_state = ST_IDLE;
			default:   next_state = ST_IDLE;
		endcase
	end

	// Interval between measurement pairs, keeps the sensor duty low
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			waitCount <= '0;
		else if (state != ST_IDLE || waitDone)
			waitCount <= '0;
		else
			waitCount <= waitCount + 32'h1;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Samples: averaged pair rounds toward zero, half-kelvin scale kept
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			firstSample <= '0;
			tempCode    <= '0;
		end else if (state == ST_FIRST && adcValid) begin
			firstSample <= adcCode;
		end else if (state == ST_SECOND && adcValid) begin
			tempCode <= sampleSum[10:1];
		end
	end

	// Converter start is a level request held while a sample is awaited
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			convStart <= 1'b0;
		else
			convStart <= (next_state == ST_FIRST || next_state == ST_SECOND)
				&& tempSenseEnable;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			calcStrobe <= 1'b0;
		else
			calcStrobe <= (state == ST_CALC);
	end

	corr_calc u_calc (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.start       (calcStrobe),
		.tempCode    (tempCode),
		.turnRef     (turnRef),
		.coeff       (selCoeff),
		.initialTrim (initialTrim),
		.fineTrim    (fineTrim),
		.netCorr     (corrValue)
	);

	// Read mux; the readout registers accept no writes at all
	always_comb begin
		case (regAddr)
			ADDR_TEMP_LOW:  next_rdata = tempCode[7:0];
			ADDR_TEMP_HIGH: next_rdata = {6'h00, tempCode[9:8]};
			ADDR_CORR_LOW:  next_rdata = corrValue[7:0];
			ADDR_CORR_HIGH: next_rdata = corrValue[15:8];
			ADDR_TURNOVER:  next_rdata = turnover;
			ADDR_HOT_COEFF: next_rdata = hotCoeff;
			default:        next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			regRdata      <= 8'h00;
			netCorrection <= 16'h0000;
		end else begin
			if (regRead)
				regRdata <= next_rdata;
			netCorrection <= corrValue;
		end
	end
endmodule

// file: verif/temp_comp_monitor.sv
// Purpose: Port checker for temp_comp
// Assumes: regRdata is loaded at the edge that takes regRead
// Notes: Mirrors recall and averaging so reads can be judged
`timescale 1ns/10ps
module temp_comp_chk
	import temp_comp_pkg::*;
(
	input wire logic       ref_clk,         // Clock
	input wire logic       reset,           // Async reset
	input wire logic [7:0] recallTurnover,  // Recall value
	input wire logic [7:0] recallHotCoeff,  // Recall value
	input wire logic       tempSenseEnable, // Sense enable
	input wire logic       adcValid,        // Sample strobe
	input wire logic [9:0] adcCode,         // Sample
	input wire logic       regRead,         // Read strobe
	input wire logic [7:0] regAddr,         // Address
	input wire logic [7:0] regRdata,        // Read data
	input wire logic       convStart        // Sample request
);
	logic       seen;
	logic       half;
	logic [7:0] turn;
	logic [7:0] hot;
	logic [9:0] first;
	logic [9:0] avg;
	wire        mapped = regAddr inside {[8'h28:8'h2d]};
	// Recall is taken once; later writes must not disturb it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			seen <= 1'b0;
			half <= 1'b0;
			avg  <= 10'h000;
		end else begin
			seen <= 1'b1;
			if (!seen) turn <= recallTurnover;
			if (!seen) hot <= recallHotCoeff;
			if (adcValid) half <= ~half;
			if (adcValid) first <= adcCode;
			if (adcValid && half) avg <= 10'(({1'b0, first} + adcCode) >> 1);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_lo; regRead && regAddr == ADDR_TEMP_LOW |=> regRdata == avg[7:0];
	endproperty
	a_lo: assert property (p_lo) else $error("temp low mismatch");
	property p_hi; regRead && regAddr == ADDR_TEMP_HIGH |=>
		regRdata == {6'h00, avg[9:8]}; endproperty
	a_hi: assert property (p_hi) else $error("temp high mismatch");
	property p_turn; regRead && regAddr == ADDR_TURNOVER |=>
		regRdata == {3'h0, turn[4:0]}; endproperty
	a_turn: assert property (p_turn) else $error("turnover wrong");
	property p_hot; regRead && regAddr == ADDR_HOT_COEFF |=>
		regRdata == {1'b0, hot[6:0]}; endproperty
	a_hot: assert property (p_hot) else $error("hot coeff wrong");
	property p_sense; !tempSenseEnable |=> !convStart; endproperty
	a_sense: assert property (p_sense) else $error("sensing while off");
	property p_wait; convStart && tempSenseEnable && !adcValid |=> convStart;
	endproperty
	a_wait: assert property (p_wait) else $error("request dropped");
	property p_unmap; regRead && !mapped |=> regRdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	property p_keep; !regRead |=> $stable(regRdata); endproperty
	a_keep: assert property (p_keep) else $error("read data moved");
	c_conv: cover property ($rose(convStart));
	c_two: cover property (adcValid && half);
	c_hot: cover property (regRead && regAddr == ADDR_HOT_COEFF);
endmodule
bind temp_comp temp_comp_chk i_chk (.ref_clk(ref_clk), .reset(reset),
	.recallTurnover(recallTurnover), .recallHotCoeff(recallHotCoeff),
	.tempSenseEnable(tempSenseEnable), .adcValid(adcValid),
	.adcCode(adcCode), .regRead(regRead), .regAddr(regAddr),
	.regRdata(regRdata), .convStart(convStart));

// file: verif/tb.sv
// Purpose: Self-checking bench for temp_comp
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Two full conversions, one hot and one cold, fit the run
`timescale 1ns/10ps
module tb;
	import temp_comp_pkg::*;
	logic        ref_clk, reset, tempSenseEnable, adcValid, regWrite, regRead;
	logic [7:0]  rt, rh, coldCoeff, initialTrim, fineTrim, regAddr, regWdata;
	logic [7:0]  regRdata;
	logic [9:0]  adcCode;
	logic [15:0] netCorrection;
	logic        convStart;
	logic        rdv = 1'b0;
	logic [7:0]  q[$];
	int          errTotal, samplesChecked, rf, base;
	temp_comp i_dut (.ref_clk(ref_clk), .reset(reset), .recallTurnover(rt),
		.recallHotCoeff(rh), .coldCoeff(coldCoeff), .initialTrim(initialTrim),
		.fineTrim(fineTrim), .tempSenseEnable(tempSenseEnable),
		.adcValid(adcValid), .adcCode(adcCode), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .convStart(convStart),
		.netCorrection(netCorrection));
	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic stop_test();
		$display("checks=%0d errors=%0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One read a call; the note goes in with the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		#2 regRead = 1'b1;
		regAddr = a;
		q.push_back(e);
		@(posedge ref_clk);
		#2 regRead = 1'b0;
	endtask
	// Answer lands one edge after the strobe, so compare at the next
	always @(posedge ref_clk) begin
		if (rdv) chk({8'h00, regRdata}, {8'h00, q.pop_front()});
		rdv <= regRead;
	end
	// Wait for a request, hand over two samples, then read back
	task automatic conv(input int a, input int b);
		int n, t, c;
		logic [15:0] e;
		n = 0;
		// Look after the edge has settled, never in its own time step
		while (convStart !== 1'b1 && n < 50000) begin
			@(posedge ref_clk);
			#2 n++;
		end
		if (n == 50000) begin
			errTotal++;
			stop_test();
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			#2 adcValid = 1'b1;
			adcCode = 10'(i ? b : a);
			@(posedge ref_clk);
			#2 adcValid = 1'b0;
		end
		repeat (6) @(posedge ref_clk);
		t = (a + b) >> 1;
		c = (t > rf) ? int'(rh[6:0]) : int'(coldCoeff);
		e = 16'(initialTrim + fineTrim - c * (t - rf) * (t - rf) / 4096);
		rd(ADDR_TEMP_LOW, t[7:0]);
		rd(ADDR_TEMP_HIGH, {6'h00, t[9:8]});
		rd(ADDR_CORR_LOW, e[7:0]);
		rd(ADDR_CORR_HIGH, e[15:8]);
		chk(netCorrection, e);
	endtask
	initial begin
		{reset, tempSenseEnable, adcValid, regWrite, regRead} = 5'h10;
		{adcCode, regAddr, regWdata} = '0;
		errTotal = 0;
		samplesChecked = 0;
		void'($urandom(32'h1a1323c0));
		{rt, rh, coldCoeff, initialTrim, fineTrim} = 40'({$urandom, $urandom});
		rf = rt[4] ? 596 - int'(rt[3:0]) : 596 + int'(rt[3:0]);
		repeat (4) @(posedge ref_clk);
		#2 reset = 1'b0;
		// Host writes to the recalled bytes must leave them alone
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			#2 regWrite = 1'b1;
			regAddr = k ? ADDR_HOT_COEFF : ADDR_TURNOVER;
			regWdata = ~(k ? rh : rt);
			@(posedge ref_clk);
			#2 regWrite = 1'b0;
			rd(ADDR_TURNOVER, {3'h0, rt[4:0]});
			rd(ADDR_HOT_COEFF, {1'b0, rh[6:0]});
		end
		rd(8'h2e, 8'h00);
		tempSenseEnable = 1'b1;
		base = rf + 10 + int'($urandom % 60);
		conv(base, base + 1);
		base = rf - 10 - int'($urandom % 60);
		conv(base, base + 3);
		repeat (2) @(posedge ref_clk);
		stop_test();
	end
endmodule
